// File: hw/rts_regs.svh
// Offsets, field positions, reset values and timing counts of the sequencer
`ifndef RTS_REGS_SVH
`define RTS_REGS_SVH
`define CLK_PERIOD_NS     20
`define INTOSC_TICK_NS    1000
`define INTOSC_TICK_CYC   ((`INTOSC_TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POWERUP_DELAY_MS  96
`define POWERUP_TICKS     (`POWERUP_DELAY_MS * 1000000 / `INTOSC_TICK_NS)
`define STARTUP_PERIODS   11'h400
`define ADDR_CTRL         8'h00
`define ADDR_STATUS       8'h04
`define CTRL_MODE_LSB     0
`define CTRL_BOD_EN_BIT   2
`define CTRL_IRQDIS_BIT   3
`define CTRL_RESET        4'h8
`define FLAGS_POWERON     4'hc
`define FLAGS_BROWNOUT    4'he
`define STATUS_TOP_BIT    1'h1
`define PHASE_FIRST       2'h0
`endif

// File: hw/rts_pkg.sv
// Types shared by the reset sequencer
package rts_pkg;
  typedef enum logic [2:0] {
    ST_RUN    = 3'b000,
    ST_HOLD   = 3'b001,
    ST_TIMING = 3'b010,
    ST_SLEEP  = 3'b011,
    ST_WAKE   = 3'b100
  } seq_state_type;
  typedef enum logic [1:0] {
    DLY_NONE = 2'b00,
    DLY_OSC  = 2'b01,
    DLY_BOTH = 2'b10
  } delay_kind_type;
  typedef enum logic [1:0] {
    crystal_osc_mode      = 2'b00,
    low_freq_osc_mode     = 2'b01,
    external_clock_mode   = 2'b10,
    resistor_cap_osc_mode = 2'b11
  } osc_mode_type;
  typedef struct packed {
    logic timeout_flag;
    logic powerdown_flag;
    logic poweron_flag;
    logic brownout_flag;
  } reset_flags_type;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_type;
endpackage

// File: hw/reset_timeout_sequencer.sv
// Reset cause tracking, power-up timer and oscillator start-up counter
//
// The placing of the registers and strobed register access were left to the implementer.
`include "rts_regs.svh"
module reset_timeout_sequencer #(
  parameter int unsigned POWERUP_TICKS = `POWERUP_TICKS
) (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  // Register port
  input  wire rts_pkg::reg_req_type reg_req_i,
  output logic [7:0]                reg_rdata_o,
  // Supply monitor and pins
  input  wire logic                 supply_ok_i,
  input  wire logic                 brownout_i,
  input  wire logic                 master_clear_pin_n_i,
  input  wire logic                 osc_clk_pin_i,
  input  wire logic                 osc_amp_ok_i,
  // Core events
  input  wire logic                 watchdog_timeout_i,
  input  wire logic                 sleep_enter_i,
  input  wire logic                 irq_wake_i,
  input  wire logic                 clear_watchdog_instr_i,
  // Core control
  output logic                      core_hold_o,
  output logic [1:0]                q_phase_o,
  output logic                      pc_zero_o,
  output logic                      resume_next_o,
  output logic                      irq_vector_o,
  output logic [5:0]                cpu_status_reg_o
);
  import rts_pkg::*;

  localparam int unsigned TICK_CYC = `INTOSC_TICK_CYC;

  logic            rst_meta_q;
  logic            rst_q;
  osc_mode_type    mode_q;
  logic            bo_en_q;
  logic            irq_dis_q;
  seq_state_type   state_q;
  seq_state_type   state_d;
  delay_kind_type  kind_q;
  delay_kind_type  kind_d;
  reset_flags_type flags_q;
  reset_flags_type flags_d;
  logic            resume_q;
  logic            resume_d;
  logic            vec_q;
  logic            vec_d;
  logic [5:0]      div_q;
  logic            tick;
  logic [16:0]     pup_q;
  logic            pup_done;
  logic [10:0]     start_q;
  logic            start_done;
  logic            osc_prev_q;
  logic            osc_edge;
  logic            bo_evt;
  logic            xtal;
  logic            in_sleep;
  logic            release_w;
  delay_kind_type  wake_kind;

  // Chip reset released through two stages
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_q      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_q      <= rst_meta_q;
    end
  end

  // Control register
  always_ff @(posedge clk_i or negedge rst_q) begin
    if (!rst_q) begin
      {irq_dis_q, bo_en_q} <= 2'(`CTRL_RESET >> 2);
      mode_q               <= crystal_osc_mode;
    end else if (reg_req_i.wr && reg_req_i.addr == `ADDR_CTRL) begin
      mode_q    <= osc_mode_type'(reg_req_i.wdata[`CTRL_MODE_LSB +: 2]);
      bo_en_q   <= reg_req_i.wdata[`CTRL_BOD_EN_BIT];
      irq_dis_q <= reg_req_i.wdata[`CTRL_IRQDIS_BIT];
    end
  end

  // Read data one cycle after the strobe, zero for unmapped offsets
  always_ff @(posedge clk_i or negedge rst_q) begin
    if (!rst_q) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_req_i.rd && reg_req_i.addr == `ADDR_CTRL) begin
      reg_rdata_o <= {4'h0, irq_dis_q, bo_en_q, mode_q};
    end else if (reg_req_i.rd && reg_req_i.addr == `ADDR_STATUS) begin
      reg_rdata_o <= {2'h0, cpu_status_reg_o};
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  assign bo_evt    = bo_en_q && brownout_i;
  assign xtal      = mode_q == crystal_osc_mode || mode_q == low_freq_osc_mode;
  assign wake_kind = xtal ? DLY_OSC : DLY_NONE;
  assign in_sleep  = state_q == ST_SLEEP || state_q == ST_WAKE;

  // Internal oscillator tick, independent of the pin clock
  assign tick = div_q == 6'(TICK_CYC - 1);
  always_ff @(posedge clk_i or negedge rst_q) begin
    if (!rst_q) begin
      div_q <= 6'h00;
    end else if (tick) begin
      div_q <= 6'h00;
    end else begin
      div_q <= div_q + 6'h01;
    end
  end

  // Power-up timer; cleared outside the timing state so it restarts cleanly
  assign pup_done = pup_q == 17'(POWERUP_TICKS);
  always_ff @(posedge clk_i or negedge rst_q) begin
    if (!rst_q) begin
      pup_q <= 17'h00000;
    end else if (state_q != ST_TIMING) begin
      pup_q <= 17'h00000;
    end else if (tick && !pup_done) begin
      pup_q <= pup_q + 17'h00001;
    end
  end

  // Start-up counter on pin edges, gated by amplitude detect
  assign osc_edge   = osc_clk_pin_i && !osc_prev_q && osc_amp_ok_i;
  assign start_done = start_q == `STARTUP_PERIODS;
  always_ff @(posedge clk_i or negedge rst_q) begin
    if (!rst_q) begin
      osc_prev_q <= 1'b0;
      start_q    <= 11'h000;
    end else begin
      osc_prev_q <= osc_clk_pin_i;
      if (state_q != ST_TIMING && state_q != ST_WAKE) begin
        start_q <= 11'h000;
      end else if (osc_edge && !start_done) begin
        start_q <= start_q + 11'h001;
      end
    end
  end

  // Event priority: supply, brown-out, clear pin, watchdog, interrupt wake
  always_comb begin
    state_d  = state_q;
    kind_d   = kind_q;
    flags_d  = flags_q;
    resume_d = resume_q;
    vec_d    = vec_q;
    if (reg_req_i.wr && reg_req_i.addr == `ADDR_STATUS) begin
      flags_d.poweron_flag  = flags_q.poweron_flag | reg_req_i.wdata[1];
      flags_d.brownout_flag = flags_q.brownout_flag | reg_req_i.wdata[0];
    end
    if (!supply_ok_i) begin
      state_d  = ST_HOLD;
      kind_d   = DLY_BOTH;
      flags_d  = `FLAGS_POWERON;
      resume_d = 1'b0;
    end else if (bo_evt) begin
      state_d  = ST_HOLD;
      kind_d   = DLY_BOTH;
      flags_d  = `FLAGS_BROWNOUT;
      resume_d = 1'b0;
    end else if (!master_clear_pin_n_i) begin
      state_d  = ST_HOLD;
      resume_d = 1'b0;
      if (state_q == ST_RUN) begin
        kind_d                 = DLY_NONE;
        flags_d.timeout_flag   = 1'b1;
        flags_d.powerdown_flag = 1'b1;
      end else if (in_sleep) begin
        kind_d                 = wake_kind;
        flags_d.timeout_flag   = 1'b1;
        flags_d.powerdown_flag = 1'b0;
      end
    end else if (watchdog_timeout_i && state_q == ST_RUN) begin
      state_d                = ST_HOLD;
      kind_d                 = DLY_NONE;
      flags_d.timeout_flag   = 1'b0;
      flags_d.powerdown_flag = 1'b1;
      resume_d               = 1'b0;
    end else if (watchdog_timeout_i && state_q == ST_SLEEP) begin
      state_d                = ST_HOLD;
      kind_d                 = wake_kind;
      flags_d.timeout_flag   = 1'b0;
      flags_d.powerdown_flag = 1'b0;
      resume_d               = 1'b0;
    end else if (irq_wake_i && state_q == ST_SLEEP) begin
      state_d                = xtal ? ST_WAKE : ST_RUN;
      flags_d.timeout_flag   = 1'b1;
      flags_d.powerdown_flag = 1'b0;
      resume_d               = 1'b1;
      vec_d                  = !irq_dis_q;
    end else begin
      case (state_q)
        ST_HOLD: begin
          state_d = (kind_q == DLY_NONE) ? ST_RUN : ST_TIMING;
        end
        ST_TIMING: begin
          if (start_done && (pup_done || kind_q == DLY_OSC)) begin
            state_d = ST_RUN;
          end
        end
        ST_WAKE: begin
          if (start_done) begin
            state_d = ST_RUN;
          end
        end
        ST_RUN: begin
          if (sleep_enter_i) begin
            state_d                = ST_SLEEP;
            flags_d.timeout_flag   = 1'b1;
            flags_d.powerdown_flag = 1'b0;
          end else if (clear_watchdog_instr_i) begin
            flags_d.timeout_flag   = 1'b1;
            flags_d.powerdown_flag = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign release_w = state_d == ST_RUN && state_q != ST_RUN;

  // Sequencer state; power-on holds first after reset
  always_ff @(posedge clk_i or negedge rst_q) begin
    if (!rst_q) begin
      state_q  <= ST_HOLD;
      kind_q   <= DLY_BOTH;
      flags_q  <= `FLAGS_POWERON;
      resume_q <= 1'b0;
      vec_q    <= 1'b0;
    end else begin
      state_q  <= state_d;
      kind_q   <= kind_d;
      flags_q  <= flags_d;
      resume_q <= resume_d;
      vec_q    <= vec_d;
    end
  end

  // Core controls; registered so release lines up with the first phase
  always_ff @(posedge clk_i or negedge rst_q) begin
    if (!rst_q) begin
      core_hold_o <= 1'b1;
      pc_zero_o   <= 1'b0;
      irq_vector_o <= 1'b0;
    end else begin
      core_hold_o  <= state_d != ST_RUN;
      pc_zero_o    <= release_w && !resume_d;
      irq_vector_o <= release_w && resume_d && vec_d;
    end
  end

  // Phase generator parked in its first phase while held
  always_ff @(posedge clk_i or negedge rst_q) begin
    if (!rst_q) begin
      q_phase_o <= `PHASE_FIRST;
    end else if (state_d != ST_RUN || core_hold_o) begin
      // Released core must see the first phase in its first cycle
      q_phase_o <= `PHASE_FIRST;
    end else begin
      q_phase_o <= q_phase_o + 2'h1;
    end
  end

  assign resume_next_o    = resume_q;
  assign cpu_status_reg_o = {`STATUS_TOP_BIT, irq_dis_q, flags_q};

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_q);

  por_hold_a : assert property (!supply_ok_i |=> core_hold_o)
    else $error("core not held under low supply");
  pup_hold_a : assert property (
    state_q == ST_TIMING && kind_q == DLY_BOTH && !pup_done |=> core_hold_o)
    else $error("core released while power-up timer counts");
  amp_gate_a : assert property (
    state_q == ST_TIMING && !osc_amp_ok_i |=> $stable(start_q))
    else $error("start-up counter moved without amplitude");
  release_both_a : assert property (
    $fell(core_hold_o) && $past(state_q) == ST_TIMING && $past(kind_q) == DLY_BOTH
    |-> $past(pup_done) && $past(start_done))
    else $error("power-on release before both timers");
  por_status_a : assert property (
    !supply_ok_i |=> cpu_status_reg_o[3:0] == 4'hc && core_hold_o)
    else $error("power-on status wrong");
  bor_status_a : assert property (
    supply_ok_i && bo_evt |=> cpu_status_reg_o[3:0] == 4'he)
    else $error("brown-out status wrong");
  wdog_run_a : assert property (
    state_q == ST_RUN && supply_ok_i && !bo_evt && master_clear_pin_n_i && watchdog_timeout_i
    |=> cpu_status_reg_o[3:2] == 2'b01 ##1 (!core_hold_o && pc_zero_o))
    else $error("watchdog reset sequence wrong");
  phase_park_a : assert property (core_hold_o |-> q_phase_o == `PHASE_FIRST)
    else $error("phase moved while held");
  release_phase_a : assert property ($fell(core_hold_o) |-> q_phase_o == `PHASE_FIRST)
    else $error("core released outside the first phase");
  master_clear_pin_fast_a : assert property (
    state_q == ST_HOLD && kind_q == DLY_NONE && supply_ok_i && !bo_evt
    && master_clear_pin_n_i |=> (!core_hold_o && pc_zero_o))
    else $error("clear-pin release was delayed");
endmodule

// File: sim/supply_pin_model.sv
// Model of the supply monitor, clear pin circuit and clock source
module supply_pin_model (
  // Clock
  input  wire logic clk_i,
  // Scenario controls
  input  wire logic supply_want_i,
  input  wire logic pin_low_i,
  input  wire logic osc_run_i,
  input  wire logic amp_good_i,
  // Pins toward the device
  output logic      supply_ok_o,
  output logic      master_clear_pin_n_o,
  output logic      osc_clk_pin_o,
  output logic      osc_amp_ok_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pin follows supply, so it is never high before the supply is good
  assign supply_ok_o          = supply_want_i;
  assign master_clear_pin_n_o = supply_want_i & ~pin_low_i;
  // Amplitude may lag the oscillator, the slow answer
  assign osc_amp_ok_o         = osc_run_i & amp_good_i;
  // Stopped oscillator sits low
  initial osc_clk_pin_o = 1'b0;
  always @(posedge clk_i) begin
    osc_clk_pin_o <= osc_run_i & ~osc_clk_pin_o;
  end
endmodule

// File: sim/reset_timeout_sequencer_tb_top.sv
// Testbench for the reset sequencer
`include "rts_regs.svh"
module reset_timeout_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Short power-up count; scenarios let either timer finish last
  localparam int unsigned TICKS = 60;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  rts_pkg::reg_req_type req = '0;
  logic [7:0] rdata, v;
  logic supply_want = 1'b0, pin_low = 1'b0, osc_run = 1'b0, amp_good = 1'b0;
  logic supply_ok, clr_n, osc_pin, amp_ok, hold, pcz, resn, vec;
  // Event strobes toward the brown-out and core event inputs, one bit each
  localparam logic [4:0] EV_BO = 5'h01, EV_WDOG = 5'h02, EV_SLP = 5'h04;
  localparam logic [4:0] EV_IRQ = 5'h08, EV_CLRW = 5'h10;
  logic [4:0] ev = 5'h00;
  logic vec_seen = 1'b0;
  logic [1:0] phase;
  logic [5:0] status;
  int n_errors = 0;
  int check_count = 0;
  int waited;
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) if (vec) vec_seen <= 1'b1;
  supply_pin_model part_u (.clk_i(clk_i), .supply_want_i(supply_want), .pin_low_i(pin_low),
    .osc_run_i(osc_run), .amp_good_i(amp_good), .supply_ok_o(supply_ok),
    .master_clear_pin_n_o(clr_n), .osc_clk_pin_o(osc_pin), .osc_amp_ok_o(amp_ok));
  reset_timeout_sequencer #(.POWERUP_TICKS(TICKS)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .reg_req_i(req), .reg_rdata_o(rdata), .supply_ok_i(supply_ok), .brownout_i(ev[0]),
    .master_clear_pin_n_i(clr_n), .osc_clk_pin_i(osc_pin), .osc_amp_ok_i(amp_ok),
    .watchdog_timeout_i(ev[1]), .sleep_enter_i(ev[2]), .irq_wake_i(ev[3]),
    .clear_watchdog_instr_i(ev[4]), .core_hold_o(hold), .q_phase_o(phase), .pc_zero_o(pcz),
    .resume_next_o(resn), .irq_vector_o(vec), .cpu_status_reg_o(status));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    req <= '0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    req <= '0;
    #1 d = rdata;
  endtask
  task automatic pulse(input logic [4:0] m);
    @(posedge clk_i);
    ev <= m;
    @(posedge clk_i);
    ev <= 5'h00;
  endtask
  // Waits for release, then checks phase, restart pulse and flags
  task automatic wait_release(input int lim, input logic pz, input logic [7:0] st);
    waited = 0;
    while (hold !== 1'b0 && waited < lim) begin
      cyc(1);
      waited++;
    end
    chk(hold, 8'h00);
    chk(phase, `PHASE_FIRST);
    chk(pcz, pz);
    chk(status, st);
    cyc(1);
    chk(pcz, 8'h00);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #500us;
    n_errors++;
    complete_run();
  end
  initial begin
    cyc(3);
    chk(status, 8'h3c);
    chk(phase, `PHASE_FIRST);
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    cyc(3);
    rd_reg(`ADDR_CTRL, v);
    chk(v, `CTRL_RESET);
    rd_reg(8'h20, v);
    chk(v, 8'h00);
    // Oscillator runs before its amplitude is good
    supply_want <= 1'b1;
    osc_run <= 1'b1;
    // Held past the power-up count, so only the gated counter holds the core
    cyc(3100);
    chk(hold, 8'h01);
    amp_good <= 1'b1;
    wait_release(4000, 1'b1, 8'h3c);
    chk(8'(waited >= 2040), 8'h01);
    wr_reg(`ADDR_STATUS, 8'h03);
    rd_reg(`ADDR_STATUS, v);
    chk(v, 8'h3f);
    pin_low <= 1'b1;
    cyc(3);
    chk(hold, 8'h01);
    pin_low <= 1'b0;
    wait_release(8, 1'b1, 8'h3f);
    pulse(EV_WDOG);
    #1;
    chk(hold, 8'h01);
    wait_release(8, 1'b1, 8'h37);
    pulse(EV_CLRW);
    cyc(1);
    chk(status, 8'h3f);
    // Sleep in crystal mode, woken by the watchdog, then by an interrupt
    pulse(EV_SLP);
    cyc(1);
    chk(status, 8'h3b);
    pulse(EV_WDOG);
    cyc(2);
    wait_release(3000, 1'b1, 8'h33);
    chk(8'(waited >= 2040), 8'h01);
    pulse(EV_SLP);
    pulse(EV_IRQ);
    wait_release(3000, 1'b0, 8'h3b);
    chk(8'(waited >= 2040), 8'h01);
    chk({resn, vec_seen}, 8'h02);
    // Interrupt wakes in external clock mode, vector off then on
    wr_reg(`ADDR_CTRL, 8'h0a);
    pulse(EV_SLP);
    pulse(EV_IRQ);
    cyc(6);
    chk(status, 8'h3b);
    chk({resn, vec_seen, pcz}, 8'h04);
    wr_reg(`ADDR_CTRL, 8'h02);
    pulse(EV_SLP);
    pulse(EV_IRQ);
    cyc(6);
    chk(status, 8'h2b);
    chk({resn, vec_seen}, 8'h03);
    // Brown-out ignored while detection is off
    pulse(EV_BO);
    cyc(2);
    chk(hold, 8'h00);
    wr_reg(`ADDR_CTRL, 8'h0e);
    // Oscillator already good here, so the power-up count finishes last
    pulse(EV_BO);
    cyc(2);
    wait_release(4000, 1'b1, 8'h3e);
    chk(8'(waited >= (TICKS - 1) * `INTOSC_TICK_CYC - 4), 8'h01);
    supply_want <= 1'b0;
    cyc(2);
    chk({hold, phase}, 8'h04);
    chk(status, 8'h3c);
    complete_run();
  end
endmodule
